// File: bspm_ctrl.v
// Boot strap sampling and power mode control of the secure element
`timescale 1ns/1ps
`include "bspm_map.vh"
//
// Overview of operation
// - The device is only an I2C target and supports transfers up to 400 kbit/s in Fast-mode.
// - After power-on the strap pins and both I2C lines are sampled and set up the interface.
// - Activation 0 with both lines low gives no address; activation 1 with lines high gives 0x90 or 0x92.
// - Sleep is entered on a sleep request while running, freezing clocks and execution but keeping state.
// - In sleep every I/O pin holds the level it had when sleep began.
// - In sleep the voltage, temperature, light and glitch sensors and the shield monitor are off.
// - Sleep ends on a reset on the reset pin or on a falling edge of the I2C data line.
// - Deep sleep is entered only by holding the reset pin low for more than 500 us.
// - In deep sleep internal power is off and every digital pad is high impedance.
// - Releasing the reset pin high ends deep sleep.
module bspm_ctrl #(
	parameter STRAP_HOLD_CYC = `BSPM_STRAP_HOLD_CYC,
	parameter DSLP_LOW_CYC = `BSPM_DSLP_LOW_CYC
) (
	input wire clk_sys_in,
	input wire reset_n_in,
	input wire rst_pin_n_in,
	input wire interface_activation_strap_in,
	input wire address_select_strap_in,
	input wire scl_pin_in,
	input wire sda_pin_in,
	input wire sleep_request_in,
	input wire [1:0] pad_drive_oe_in,
	input wire [1:0] pad_drive_val_in,
	output reg target_enable_out,
	output reg [7:0] target_addr_out,
	output reg config_valid_out,
	output reg core_clock_enable_out,
	output reg core_reset_n_out,
	output reg sleep_active_out,
	output reg deep_sleep_active_out,
	output reg internal_power_on_out,
	output reg sensors_enable_out,
	output reg [1:0] pad_oe_out,
	output reg [1:0] pad_val_out
);
	// ==========================================================
	// Input synchronisers
	// Pins and straps come from the host's domain and pass two stages first
	reg [4:0] sync1_q;
	reg [4:0] sync2_q;
	reg sda_prev_q;
	wire rst_pin_n_s = sync2_q[0];
	wire act_s = sync2_q[1];
	wire sel_s = sync2_q[2];
	wire scl_s = sync2_q[3];
	wire sda_s = sync2_q[4];
	// Wake edge reads the second stage only, never the possibly metastable first
	wire sda_fall = sda_prev_q & ~sda_s;

	always @(posedge clk_sys_in) begin
		if (!reset_n_in) begin
			// Idle pin levels, so release gives no false wake edge or pin reset
			sync1_q <= 5'h1F;
			sync2_q <= 5'h1F;
			sda_prev_q <= 1'b1;
		end else begin
			sync1_q <= {sda_pin_in, scl_pin_in, address_select_strap_in,
				interface_activation_strap_in, rst_pin_n_in};
			sync2_q <= sync1_q;
			sda_prev_q <= sda_s;
		end
	end

	// ==========================================================
	// Power mode state machine
	localparam [4:0] ST_BOOT = 5'h01;
	localparam [4:0] ST_RUN = 5'h02;
	localparam [4:0] ST_SLEEP = 5'h04;
	localparam [4:0] ST_DSLP = 5'h08;
	localparam [4:0] ST_HALT = 5'h10;

	reg [4:0] state_q;
	reg [4:0] state_d;
	reg [23:0] cnt_q;
	reg [23:0] low_cnt_q;
	reg [23:0] low_cnt_d;
	wire dslp_hit = (low_cnt_q >= DSLP_LOW_CYC[23:0]);

	// Reset pin low time, counted in every mode so deep sleep can be reached from any
	// The count saturates, so a pin held low for ever never wraps out of deep sleep
	always @* begin
		if (rst_pin_n_s)
			low_cnt_d = 24'h0000_00;
		else if (dslp_hit)
			low_cnt_d = low_cnt_q;
		else
			low_cnt_d = low_cnt_q + 24'h0000_01;
	end

	always @* begin
		state_d = state_q;
		case (state_q)
			ST_BOOT: begin
				// Wait the hold time, then capture the straps
				// A strap changed inside the window is taken as it stands at the end
				if (cnt_q >= STRAP_HOLD_CYC[23:0] - 24'h0000_01)
					state_d = ST_RUN;
			end
			ST_RUN: begin
				// Sleep requests count only here; other states ignore them
				if (!rst_pin_n_s)
					state_d = ST_HALT;
				else if (sleep_request_in)
					state_d = ST_SLEEP;
			end
			ST_SLEEP: begin
				// A pin reset wins over a wake edge in the same cycle
				if (!rst_pin_n_s)
					state_d = ST_HALT;
				else if (sda_fall)
					state_d = ST_RUN;
			end
			ST_HALT: begin
				// Short pulse is an ordinary reset; a long one is deep sleep
				// The low count started in BOOT, RUN or SLEEP, so time spent here already counts
				if (dslp_hit)
					state_d = ST_DSLP;
				else if (rst_pin_n_s)
					state_d = ST_BOOT;
			end
			ST_DSLP: begin
				// Release goes through BOOT so the straps are sampled afresh
				if (rst_pin_n_s)
					state_d = ST_BOOT;
			end
			default: state_d = ST_BOOT;
		endcase
	end

	always @(posedge clk_sys_in) begin
		if (!reset_n_in) begin
			state_q <= ST_BOOT;
			cnt_q <= 24'h0000_00;
			low_cnt_q <= 24'h0000_00;
		end else begin
			state_q <= state_d;
			low_cnt_q <= low_cnt_d;
			// Hold counter runs only in BOOT and restarts on every entry
			if (state_q == ST_BOOT && state_d == ST_BOOT)
				cnt_q <= cnt_q + 24'h0000_01;
			else
				cnt_q <= 24'h0000_00;
		end
	end

	// ==========================================================
	// Strap decode
	// Gives {enable, write address}; any strap mix outside the two addressed
	// rows gets no address, so a floating strap never yields a target that
	// the host did not ask for
	function [8:0] bspm_strap_decode;
		input act_lvl;
		input sel_lvl;
		input scl_lvl;
		input sda_lvl;
		begin
			if (act_lvl && scl_lvl && sda_lvl)
				bspm_strap_decode = {1'b1, (sel_lvl ? `BSPM_ADDR_WR_SEL1 : `BSPM_ADDR_WR_SEL0)};
			else
				bspm_strap_decode = {1'b0, `BSPM_ADDR_NONE};
		end
	endfunction

	wire [8:0] strap_cfg = bspm_strap_decode(act_s, sel_s, scl_s, sda_s);

	// ==========================================================
	// Outputs
	// Every output is registered from the next state, so it moves on the edge entering a mode
	always @(posedge clk_sys_in) begin
		if (!reset_n_in) begin
			target_enable_out <= 1'b0;
			target_addr_out <= `BSPM_ADDR_NONE;
			config_valid_out <= 1'b0;
			core_clock_enable_out <= 1'b0;
			core_reset_n_out <= 1'b0;
			sleep_active_out <= 1'b0;
			deep_sleep_active_out <= 1'b0;
			internal_power_on_out <= 1'b1;
			sensors_enable_out <= 1'b0;
			pad_oe_out <= 2'h0;
			pad_val_out <= 2'h0;
		end else begin
			sleep_active_out <= (state_d == ST_SLEEP);
			deep_sleep_active_out <= (state_d == ST_DSLP);
			internal_power_on_out <= (state_d != ST_DSLP);
			core_clock_enable_out <= (state_d == ST_RUN);
			core_reset_n_out <= (state_d == ST_RUN) || (state_d == ST_SLEEP);
			sensors_enable_out <= (state_d == ST_RUN);
			if (state_q == ST_BOOT && state_d == ST_RUN) begin
				config_valid_out <= 1'b1;
				// Only target mode exists; the Fast-mode rate cap is kept by the framing engine
				target_enable_out <= strap_cfg[8];
				target_addr_out <= strap_cfg[7:0];
			end else if (state_d == ST_BOOT || state_d == ST_DSLP) begin
				// Volatile configuration is lost with internal power
				config_valid_out <= 1'b0;
				target_enable_out <= 1'b0;
				target_addr_out <= `BSPM_ADDR_NONE;
			end
			if (state_d == ST_DSLP || state_d == ST_BOOT) begin
				// Enables low float the pads; the level is parked at zero
				pad_oe_out <= 2'h0;
				pad_val_out <= 2'h0;
			end else if (state_d == ST_RUN) begin
				pad_oe_out <= pad_drive_oe_in;
				pad_val_out <= pad_drive_val_in;
			end else begin
				// In sleep and halt the pads keep their last level
				pad_oe_out <= pad_oe_out;
				pad_val_out <= pad_val_out;
			end
		end
	end
endmodule // bspm_ctrl

// File: bspm_ctrl_props.sv
// Assertions on the boot strap and power mode controller
`timescale 1ns/1ps
module bspm_ctrl_props (
	input wire clk_sys_in,
	input wire reset_n_in,
	input wire rst_pin_n_in,
	input wire sda_pin_in,
	input wire sleep_request_in,
	input wire target_enable_out,
	input wire [7:0] target_addr_out,
	input wire config_valid_out,
	input wire core_clock_enable_out,
	input wire sleep_active_out,
	input wire deep_sleep_active_out,
	input wire internal_power_on_out,
	input wire sensors_enable_out,
	input wire [1:0] pad_oe_out,
	input wire [1:0] pad_val_out
);
default clocking @(posedge clk_sys_in); endclocking
default disable iff (!reset_n_in);
AST_SLP_CLK: assert property (sleep_active_out |-> !core_clock_enable_out) else $error("clk");
AST_SLP_SNS: assert property (sleep_active_out |-> !sensors_enable_out) else $error("sns");
AST_SLP_PAD: assert property (sleep_active_out && $past(sleep_active_out) |->
	$stable(pad_oe_out) && $stable(pad_val_out)) else $error("pad");
AST_SLP_ENT: assert property ($rose(sleep_active_out) |-> $past(sleep_request_in)) else $error("ent");
AST_WAKE: assert property (sleep_active_out && $fell(sda_pin_in) |->
	##[1:6] !sleep_active_out) else $error("wake");
AST_DS_ENT: assert property ($rose(deep_sleep_active_out) |-> !$past(rst_pin_n_in, 2)) else $error("ds");
AST_DS_PWR: assert property (deep_sleep_active_out |->
	!internal_power_on_out && pad_oe_out == 2'h0) else $error("pwr");
AST_DS_EXIT: assert property (deep_sleep_active_out && $rose(rst_pin_n_in) |->
	##[1:8] !deep_sleep_active_out) else $error("exit");
AST_ADDR: assert property (config_valid_out |->
	(target_addr_out inside {8'h00, 8'h90, 8'h92}) &&
	target_enable_out == (target_addr_out != 8'h00)) else $error("addr");
AST_RESTART: assert property ($fell(deep_sleep_active_out) |-> !config_valid_out) else $error("rs");
endmodule // bspm_ctrl_props
bind bspm_ctrl bspm_ctrl_props u_props (
	.clk_sys_in(clk_sys_in),
	.reset_n_in(reset_n_in),
	.rst_pin_n_in(rst_pin_n_in),
	.sda_pin_in(sda_pin_in),
	.sleep_request_in(sleep_request_in),
	.target_enable_out(target_enable_out),
	.target_addr_out(target_addr_out),
	.config_valid_out(config_valid_out),
	.core_clock_enable_out(core_clock_enable_out),
	.sleep_active_out(sleep_active_out),
	.deep_sleep_active_out(deep_sleep_active_out),
	.internal_power_on_out(internal_power_on_out),
	.sensors_enable_out(sensors_enable_out),
	.pad_oe_out(pad_oe_out),
	.pad_val_out(pad_val_out)
);

// File: bspm_host.sv
// Host model driving straps, reset pin and bus line levels
`timescale 1ns/1ps
module bspm_host (
	input wire clk_sys_in,
	output logic rst_pin_n_out = 1,
	output logic act_out = 0,
	output logic sel_out = 0,
	output logic scl_out = 1,
	output logic sda_out = 1
);
// Levels stay put until the next call, covering the strap hold time
task strap(input logic a, s, l);
	act_out <= a;
	sel_out <= s;
	scl_out <= l;
	sda_out <= l;
endtask
task pin(input logic v);
	rst_pin_n_out <= v;
endtask
task fall;
	sda_out <= 0;
	repeat (4) @(posedge clk_sys_in);
	sda_out <= 1;
endtask
endmodule // bspm_host

// File: bspm_map.vh
// Constants for the boot strap and power mode controller
`ifndef BSPM_MAP_VH
`define BSPM_MAP_VH
// Fast-mode ceiling of the target interface, kbit/s
`define BSPM_FM_RATE_KBPS 400
// System clock period in ns
`define BSPM_CLK_PERIOD_NS 20
// Strap hold time after power-on, us
`define BSPM_STRAP_HOLD_US 500
// Reset pin low time that enters deep sleep, us
`define BSPM_DSLP_LOW_US 500
// Cycles derived from the times above (both round up, both exceed 4096)
`define BSPM_STRAP_HOLD_CYC ((`BSPM_STRAP_HOLD_US * 1000 + `BSPM_CLK_PERIOD_NS - 1) / `BSPM_CLK_PERIOD_NS)
`define BSPM_DSLP_LOW_CYC ((`BSPM_DSLP_LOW_US * 1000 + `BSPM_CLK_PERIOD_NS - 1) / `BSPM_CLK_PERIOD_NS)
// Target addresses, 8-bit write form
`define BSPM_ADDR_WR_SEL0 8'h90
`define BSPM_ADDR_WR_SEL1 8'h92
`define BSPM_ADDR_NONE 8'h00
`endif

// File: bspm_tb.sv
// Self-checking bench for the boot strap and power mode controller
`timescale 1ns/1ps
module testbench;
logic clk_sys_in = 0, reset_n_in = 0, slp = 0;
logic [1:0] oe = 0, val = 0;
wire rn, act, sel, scl, sda, en, cv, ce, crn, sa, ds, pw, se;
wire [7:0] addr;
wire [1:0] poe, pv;
integer fails = 0, comparisons = 0, i;
initial forever #10 clk_sys_in = ~clk_sys_in;
bspm_host host (.clk_sys_in(clk_sys_in), .rst_pin_n_out(rn), .act_out(act), .sel_out(sel),
	.scl_out(scl), .sda_out(sda));
bspm_ctrl #(.STRAP_HOLD_CYC(20), .DSLP_LOW_CYC(40)) uut (.clk_sys_in(clk_sys_in),
	.reset_n_in(reset_n_in), .rst_pin_n_in(rn), .interface_activation_strap_in(act),
	.address_select_strap_in(sel), .scl_pin_in(scl), .sda_pin_in(sda), .sleep_request_in(slp),
	.pad_drive_oe_in(oe), .pad_drive_val_in(val), .target_enable_out(en), .target_addr_out(addr),
	.config_valid_out(cv), .core_clock_enable_out(ce), .core_reset_n_out(crn),
	.sleep_active_out(sa), .deep_sleep_active_out(ds), .internal_power_on_out(pw),
	.sensors_enable_out(se), .pad_oe_out(poe), .pad_val_out(pv));
// ====================
// Checking and verdict
task chk(input logic [7:0] g, e);
	comparisons++;
	if (g !== e) begin
		fails++;
		$display("[ERR] %0t got %h exp %h", $time, g, e);
	end
endtask
task print_verdict;
	$display("fails=%0d comparisons=%0d", fails, comparisons);
	if (fails == 0 && comparisons > 0) $display("DONE - PASS");
	else $display("DONE - FAIL");
	$finish;
endtask
task wait_cfg;
	// Look between edges, then step back onto a rising edge for the next drive
	for (i = 0; i < 80 && cv !== 1; i++) @(negedge clk_sys_in);
	if (cv !== 1) begin
		fails++;
		print_verdict;
	end
	@(posedge clk_sys_in);
endtask
task boot(input logic a, s, l, input logic [7:0] e);
	host.strap(a, s, l);
	reset_n_in <= 0;
	repeat (4) @(posedge clk_sys_in);
	reset_n_in <= 1;
	wait_cfg;
	chk(addr, e);
	chk(en, e != 0);
endtask
task sleep_wake;
	oe <= 2'h2;
	@(posedge clk_sys_in);
	slp <= 1;
	@(posedge clk_sys_in);
	slp <= 0;
	oe <= 2'h1;
	val <= 2'h3;
	repeat (3) @(posedge clk_sys_in);
	chk({sa, ce}, 8'h02);
	chk(crn, 1);
	chk(se, 0);
	chk({poe, pv}, 8'h08);
	host.fall;
	for (i = 0; i < 20 && sa !== 0; i++) @(negedge clk_sys_in);
	chk(sa, 0);
	if (sa !== 0) print_verdict;
	@(posedge clk_sys_in);
	chk({poe, pv}, 8'h07);
	chk(se, 1);
endtask
task deep;
	// Straps change while running: the address must not follow until a restart
	host.strap(1, 1, 1);
	host.pin(0);
	repeat (20) @(posedge clk_sys_in);
	chk(addr, 8'h90);
	repeat (40) @(posedge clk_sys_in);
	chk({ds, pw, poe}, 8'h08);
	chk(addr, 8'h00);
	chk(crn, 0);
	host.pin(1);
	wait_cfg;
	chk(ds, 0);
	chk(addr, 8'h92);
endtask
task sleep_pin;
	// A short pin pulse ends sleep with an ordinary restart, not deep sleep
	slp <= 1;
	@(posedge clk_sys_in);
	slp <= 0;
	host.pin(0);
	repeat (5) @(posedge clk_sys_in);
	chk({sa, ds, crn}, 8'h00);
	host.pin(1);
	repeat (5) @(posedge clk_sys_in);
	chk({ds, cv}, 8'h00);
	wait_cfg;
	chk(addr, 8'h92);
endtask
initial begin
	boot(0, 0, 0, 8'h00);
	boot(1, 1, 1, 8'h92);
	boot(1, 0, 1, 8'h90);
	sleep_wake;
	deep;
	sleep_pin;
	print_verdict;
end
endmodule // testbench
